// *** srl_pkg.sv ***
// Notes on behaviour
// [R1] Divider tick every 4 to 512 clocks.
// [R2] Enabled latch drives true output pin.
// [R3] Enabled latch drives inverted output pin.
// [R4] True enable low hides true output.
// [R5] Set write pulses set one instruction clock.
// [R6] Reset write pulses reset one instruction clock.
// [R7] Pulse bits self clear, read zero.
// [R8] Global enable low disables latch, outputs.
// [R9] Reset input dominates simultaneous set.
// [R10] Two enables route divider tick to inputs.
// [R11] Firmware initialises latch before enabling pins.
package srl_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] LATCH_CTRL_REG_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] PULSE_ROUTE_REG_ADDR = 4'h4;
   localparam logic [ADDR_W-1:0] LATCH_STATUS_REG_ADDR = 4'h8;
   localparam logic [7:0] LATCH_CTRL_RESET = 8'h00;
   localparam logic [1:0] PULSE_ROUTE_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ROUTE_TO_SET_BIT = 1;
   localparam int ROUTE_TO_RESET_BIT = 0;
   localparam int STAT_LATCH_BIT = 0;
   localparam int STAT_SET_BIT = 1;
   localparam int STAT_RESET_BIT = 2;

   // ----------------------------------------------------------------
   // Divider and timing
   // ----------------------------------------------------------------
   localparam int DIV_SEL_W = 3;
   localparam int DIV_MIN_LOG2 = 2;
   localparam int DIV_CNT_W = 9;
   localparam int QCLK_PER_SYSCLK = 4;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic latchGlobalEnable;
      logic [DIV_SEL_W-1:0] pulseDividerSel;
      logic trueOutEnable;
      logic invOutEnable;
      logic swSetPulse;
      logic swResetPulse;
   } srl_ctrl_s;

   typedef struct packed {
      logic pulseToSetEnable;
      logic pulseToResetEnable;
   } srl_route_s;

endpackage

// *** srl_latch_ctrl.sv ***
`timescale 1ns/1ps
module srl_latch_ctrl
   import srl_pkg::*;
#(
   parameter int QCLK_CYCLES = QCLK_PER_SYSCLK
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic trueOutPin,
   output logic trueOutPinEn,
   output logic invOutPin,
   output logic invOutPinEn
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (QCLK_CYCLES < 1 || QCLK_CYCLES > 255) begin : g_bad_qclk
      $error("QCLK_CYCLES must lie between 1 and 255");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   srl_ctrl_s ctrl_q;
   srl_route_s route_q;
   logic [DIV_CNT_W-1:0] divCnt_q;
   logic [7:0] setCnt_q;
   logic [7:0] resetCnt_q;
   logic latchState_q;
   logic awReady_q;
   logic wReady_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic arReady_q;
   logic rValid_q;
   logic [1:0] rResp_q;
   logic [31:0] rData_q;
   logic trueOutPin_q;
   logic trueOutPinEn_q;
   logic invOutPin_q;
   logic invOutPinEn_q;

   // ----------------------------------------------------------------
   // Write channel decode
   // ----------------------------------------------------------------
   wire awTake = s_axi_awvalid && awReady_q;
   wire wTake = s_axi_wvalid && wReady_q;
   // Address and data are both held once neither ready is up.
   wire writeDo = !awReady_q && !wReady_q && !bValid_q;
   wire bDone = bValid_q && s_axi_bready;
   wire wrCtrl = writeDo && (awAddr_q == LATCH_CTRL_REG_ADDR);
   wire wrRoute = writeDo && (awAddr_q == PULSE_ROUTE_REG_ADDR);
   wire wrStatus = writeDo && (awAddr_q == LATCH_STATUS_REG_ADDR);
   wire wrMapped = wrCtrl || wrRoute || wrStatus;
   wire lane0 = wStrb_q[0];
   srl_ctrl_s wrCtrlVal;
   assign wrCtrlVal = srl_ctrl_s'(wData_q[7:0]);

   // ----------------------------------------------------------------
   // Read channel decode
   // ----------------------------------------------------------------
   wire arTake = s_axi_arvalid && arReady_q;
   wire rDone = rValid_q && s_axi_rready;
   wire rdCtrl = (s_axi_araddr == LATCH_CTRL_REG_ADDR);
   wire rdRoute = (s_axi_araddr == PULSE_ROUTE_REG_ADDR);
   wire rdStatus = (s_axi_araddr == LATCH_STATUS_REG_ADDR);
   srl_ctrl_s ctrlRead;
   logic [31:0] rdValue;
   logic [1:0] rdResp;
   logic [7:0] statusVal;
   logic setIn;
   logic resetIn;

   // [R7] Pulse bits read zero.
   assign ctrlRead = '{
      latchGlobalEnable: ctrl_q.latchGlobalEnable,
      pulseDividerSel: ctrl_q.pulseDividerSel,
      trueOutEnable: ctrl_q.trueOutEnable,
      invOutEnable: ctrl_q.invOutEnable,
      swSetPulse: 1'b0,
      swResetPulse: 1'b0
   };

   always_comb begin
      statusVal = 8'h00;
      statusVal[STAT_LATCH_BIT] = latchState_q;
      statusVal[STAT_SET_BIT] = setIn;
      statusVal[STAT_RESET_BIT] = resetIn;
   end

   always_comb begin
      rdValue = 32'h0000_0000;
      rdResp = RESP_OKAY;
      if (rdCtrl) begin
         rdValue[7:0] = ctrlRead;
      end else if (rdRoute) begin
         rdValue[1:0] = route_q;
      end else if (rdStatus) begin
         rdValue[7:0] = statusVal;
      end else begin
         rdResp = RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // Divider tick
   // ----------------------------------------------------------------
   // The free-running counter ticks when its low (sel + 2) bits are all
   // ones, so every code gets an exact power-of-two period.
   logic [DIV_CNT_W-1:0] divMask;
   wire [3:0] divLog2 = {1'b0, ctrl_q.pulseDividerSel} + 4'(DIV_MIN_LOG2);

   for (genvar i = 0; i < DIV_CNT_W; i++) begin : g_mask
      assign divMask[i] = (4'(i) < divLog2);
   end

   // [R1] One-cycle tick per period.
   wire divTick = ((divCnt_q & divMask) == divMask);

   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_q <= '0;
      end else begin
         divCnt_q <= divCnt_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Latch inputs
   // ----------------------------------------------------------------
   wire setActive = (setCnt_q != 8'h00);
   wire resetActive = (resetCnt_q != 8'h00);
   // [R10] Tick routing enables.
   assign setIn = setActive || (divTick && route_q.pulseToSetEnable);
   assign resetIn = resetActive || (divTick && route_q.pulseToResetEnable);
   wire swSetWrite = wrCtrl && lane0 && wrCtrlVal.swSetPulse;
   wire swResetWrite = wrCtrl && lane0 && wrCtrlVal.swResetPulse;

   // [R5] Set pulse stretch.
   always_ff @(posedge clk) begin
      if (rst) begin
         setCnt_q <= 8'h00;
      end else if (swSetWrite) begin
         setCnt_q <= 8'(QCLK_CYCLES);
      end else if (setActive) begin
         setCnt_q <= setCnt_q - 8'h01;
      end
   end

   // [R6] Reset pulse stretch.
   always_ff @(posedge clk) begin
      if (rst) begin
         resetCnt_q <= 8'h00;
      end else if (swResetWrite) begin
         resetCnt_q <= 8'(QCLK_CYCLES);
      end else if (resetActive) begin
         resetCnt_q <= resetCnt_q - 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // The latch
   // ----------------------------------------------------------------
   // A real latch powers up unknown; here it clears so simulation stays
   // defined, but firmware must still set or reset it before use.
   always_ff @(posedge clk) begin
      if (rst) begin
         latchState_q <= 1'b0;
      // [R8] Frozen while disabled.
      end else if (ctrl_q.latchGlobalEnable) begin
         // [R9] Reset dominates set.
         if (resetIn) begin
            latchState_q <= 1'b0;
         end else if (setIn) begin
            latchState_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   wire trueDrive = ctrl_q.latchGlobalEnable && ctrl_q.trueOutEnable;
   wire invDrive = ctrl_q.latchGlobalEnable && ctrl_q.invOutEnable;

   always_ff @(posedge clk) begin
      if (rst) begin
         trueOutPin_q <= 1'b0;
         trueOutPinEn_q <= 1'b0;
         invOutPin_q <= 1'b0;
         invOutPinEn_q <= 1'b0;
      end else begin
         // [R2] True output drive.
         trueOutPinEn_q <= trueDrive;
         // [R4] Hidden when disabled.
         trueOutPin_q <= trueDrive && latchState_q;
         // [R3] Inverted output drive.
         invOutPinEn_q <= invDrive;
         invOutPin_q <= invDrive && !latchState_q;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= srl_ctrl_s'(LATCH_CTRL_RESET);
      end else if (wrCtrl && lane0) begin
         ctrl_q <= wrCtrlVal;
         // [R7] Pulse bits never stored.
         ctrl_q.swSetPulse <= 1'b0;
         ctrl_q.swResetPulse <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         route_q <= srl_route_s'(PULSE_ROUTE_RESET);
      end else if (wrRoute && lane0) begin
         route_q.pulseToSetEnable <= wData_q[ROUTE_TO_SET_BIT];
         route_q.pulseToResetEnable <= wData_q[ROUTE_TO_RESET_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         awReady_q <= 1'b1;
         awAddr_q <= '0;
      end else if (awTake) begin
         awReady_q <= 1'b0;
         awAddr_q <= s_axi_awaddr;
      end else if (bDone) begin
         awReady_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wReady_q <= 1'b1;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else if (wTake) begin
         wReady_q <= 1'b0;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end else if (bDone) begin
         wReady_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else if (writeDo) begin
         bValid_q <= 1'b1;
         bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bDone) begin
         bValid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         arReady_q <= 1'b1;
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= RESP_OKAY;
      end else if (arTake) begin
         arReady_q <= 1'b0;
         rValid_q <= 1'b1;
         rData_q <= rdValue;
         rResp_q <= rdResp;
      end else if (rDone) begin
         arReady_q <= 1'b1;
         rValid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Port drive
   // ----------------------------------------------------------------
   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign trueOutPin = trueOutPin_q;
   assign trueOutPinEn = trueOutPinEn_q;
   assign invOutPin = invOutPin_q;
   assign invOutPinEn = invOutPinEn_q;

endmodule

// *** srl_latch_ctrl_asserts.sv ***
`timescale 1ns/1ps
module srl_latch_ctrl_asserts
   import srl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trueOutPin,
   input wire logic trueOutPinEn,
   input wire logic invOutPin,
   input wire logic invOutPinEn
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic rdTake = s_axi_arvalid && s_axi_arready;
   wire logic awBad = s_axi_awaddr != 4'h0 && s_axi_awaddr != 4'h4 && s_axi_awaddr != 4'h8;
   wire logic arBad = s_axi_araddr != 4'h0 && s_axi_araddr != 4'h4 && s_axi_araddr != 4'h8;
   // ----------------------------------------------------------------
   // Pin and bus relations
   // ----------------------------------------------------------------
   a_true_hidden: assert property (
      !trueOutPinEn |-> !trueOutPin) else $error("true pin shows data while undriven");
   a_inv_hidden: assert property (
      !invOutPinEn |-> !invOutPin) else $error("inverted pin shows data while undriven");
   a_pins_opposite: assert property (
      trueOutPinEn && invOutPinEn |-> trueOutPin != invOutPin)
      else $error("driven pins are not complementary");
   a_ctrl_pulse_zero: assert property (
      rdTake && s_axi_araddr == LATCH_CTRL_REG_ADDR |=> s_axi_rvalid && s_axi_rdata[1:0] == 2'h0)
      else $error("pulse bits read back nonzero");
   a_write_answer: assert property (
      wrBoth |-> !s_axi_bvalid ##1 !s_axi_awready ##1 s_axi_bvalid)
      else $error("write response not after two cycles");
   a_write_unmapped: assert property (
      wrBoth && awBad |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
   a_read_unmapped: assert property (
      rdTake && arBad |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule
bind srl_latch_ctrl srl_latch_ctrl_asserts u_chk (
   .clk(clk),
   .rst(rst),
   .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .trueOutPin(trueOutPin),
   .trueOutPinEn(trueOutPinEn),
   .invOutPin(invOutPin),
   .invOutPinEn(invOutPinEn)
);

// *** srl_latch_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module srl_latch_ctrl_tb_top;
   import srl_pkg::*;
   logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic trueOutPin, trueOutPinEn, invOutPin, invOutPinEn;
   int miscompares = 0, checksDone = 0, cyc = 0, s, t1, t2;
   srl_latch_ctrl dut (
      .clk(clk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .trueOutPin(trueOutPin),
      .trueOutPinEn(trueOutPinEn),
      .invOutPin(invOutPin),
      .invOutPinEn(invOutPinEn)
   );
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task report_and_stop;
      if (miscompares == 0 && checksDone > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task fail(input string m);
      $display("mismatch at %0t: %s", $time, m);
      miscompares++;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp, input string m);
      checksDone++;
      if (got !== exp) fail(m);
   endtask
   task tick(inout int n, input int lim);
      @(posedge clk);
      n++;
      if (n > lim) begin
         fail("wait limit reached");
         report_and_stop();
      end
   endtask
   // Each bus task starts one edge late so a strobe is never lowered and raised in one step.
   task axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      bit awDone, wDone;
      n = 0;
      awDone = 0;
      wDone = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(awDone && wDone)) begin
         tick(n, 50);
         if (s_axi_awvalid && s_axi_awready) begin
            awDone = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wDone = 1;
            s_axi_wvalid <= 0;
         end
      end
      do tick(n, 50); while (s_axi_bvalid !== 1'b1);
      check(s_axi_bresp, er, "write response");
      s_axi_bready <= 0;
   endtask
   task axiRead(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do tick(n, 50); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do tick(n, 50); while (s_axi_rvalid !== 1'b1);
      check(s_axi_rdata, ed, "read data");
      check(s_axi_rresp, er, "read response");
      s_axi_rready <= 0;
   endtask
   task pins(input logic [3:0] e);
      repeat (10) @(posedge clk);
      check({28'h0, trueOutPinEn, trueOutPin, invOutPinEn, invOutPin}, {28'h0, e}, "pins");
   endtask
   task waitPin(input logic v, input int lim, output int t);
      int n;
      n = 0;
      while (trueOutPin !== v) tick(n, lim);
      t = cyc;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      axiRead(LATCH_CTRL_REG_ADDR, 32'h0, RESP_OKAY);
      axiRead(PULSE_ROUTE_REG_ADDR, 32'h0, RESP_OKAY);
      axiRead(4'hC, 32'h0, RESP_SLVERR);
      axiWrite(4'hC, 32'hFF, RESP_SLVERR);
      axiWrite(LATCH_STATUS_REG_ADDR, 32'hFF, RESP_OKAY);
      pins(4'h0);
      axiWrite(LATCH_CTRL_REG_ADDR, 32'h82, RESP_OKAY);
      pins(4'h0);
      axiWrite(LATCH_CTRL_REG_ADDR, 32'h8E, RESP_OKAY);
      axiRead(LATCH_STATUS_REG_ADDR, 32'h3, RESP_OKAY);
      pins(4'hE);
      axiRead(LATCH_CTRL_REG_ADDR, 32'h8C, RESP_OKAY);
      axiRead(LATCH_STATUS_REG_ADDR, 32'h1, RESP_OKAY);
      axiWrite(LATCH_CTRL_REG_ADDR, 32'h8F, RESP_OKAY);
      axiRead(LATCH_STATUS_REG_ADDR, 32'h6, RESP_OKAY);
      pins(4'hB);
      axiWrite(LATCH_CTRL_REG_ADDR, 32'h84, RESP_OKAY);
      pins(4'h3);
      axiWrite(LATCH_CTRL_REG_ADDR, 32'h0E, RESP_OKAY);
      pins(4'h0);
      axiWrite(LATCH_CTRL_REG_ADDR, 32'h8C, RESP_OKAY);
      pins(4'hB);
      // The tick phase is free running, so only the gap between two rises is exact.
      for (s = 0; s < 8; s++) begin
         axiWrite(PULSE_ROUTE_REG_ADDR, 32'h2, RESP_OKAY);
         axiWrite(LATCH_CTRL_REG_ADDR, {24'h0, 1'b1, s[2:0], 4'h9}, RESP_OKAY);
         waitPin(1'b0, 20, t1);
         waitPin(1'b1, (4 << s) + 8, t1);
         axiWrite(LATCH_CTRL_REG_ADDR, {24'h0, 1'b1, s[2:0], 4'h9}, RESP_OKAY);
         waitPin(1'b0, 20, t2);
         waitPin(1'b1, (4 << s) + 8, t2);
         if (s >= 2) check(t2 - t1, 4 << s, "tick period");
      end
      axiWrite(PULSE_ROUTE_REG_ADDR, 32'h1, RESP_OKAY);
      waitPin(1'b0, 520, t1);
      axiRead(PULSE_ROUTE_REG_ADDR, 32'h1, RESP_OKAY);
      // A write with byte lane 0 off is answered but must leave the register alone.
      s_axi_wstrb <= 4'hE;
      axiWrite(PULSE_ROUTE_REG_ADDR, 32'h2, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axiRead(PULSE_ROUTE_REG_ADDR, 32'h1, RESP_OKAY);
      report_and_stop();
   end
endmodule
